// ==== shared/ext_pin_regs.vh ====
// Register map, field codes and reset values of the external pin interrupt unit.
`ifndef EXT_PIN_REGS_VH
`define EXT_PIN_REGS_VH

// Register indices; the byte address is four times the index.
`define IDX_CHAN_REQUEST_ENABLES 10'h00ca
`define IDX_CHAN_REQUEST_FLAGS 10'h00cb
`define IDX_DETECT_COND_LOW 10'h00cc
`define IDX_DETECT_COND_HIGH 10'h00cd
`define IDX_PIN_SOURCE_SELECT 10'h00ce
`define IDX_PIN_STATE 10'h00d0
`define IDX_EVENT_STATUS 10'h00d1
`define IDX_EVENT_MASK 10'h00d2

// Reset values.
`define RST_ENABLES 8'h00
`define RST_FLAGS 8'h00
`define RST_COND 8'h00
`define RST_SELECT 8'h00
`define RST_EVENT 8'h00
`define RST_FILL 2'h0

// Cycles after reset before pin hits are trusted.
`define SYNC_FILL_CYCLES 2'h3

// Detection condition codes.
`define COND_LOW 2'h0
`define COND_HIGH 2'h1
`define COND_RISE 2'h2
`define COND_FALL 2'h3

// Read-modify-write flag read value.
`define FLAGS_RMW_VALUE 8'hff

// Channel groups of the two vectors.
`define VEC0_LSB 0
`define VEC1_LSB 4

// Bus responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== verilog/ext_pin_sync2.v ====
// Two-stage synchroniser for asynchronous pin levels.
`timescale 1ns/1ps
module ext_pin_sync2 #(
   parameter WIDTH = 8
) (
   input wire aclk,
   input wire aresetn,
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_r;
   reg [WIDTH-1:0] sync_r;

   always @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= {WIDTH{1'b0}};
         sync_r <= {WIDTH{1'b0}};
      end else begin
         meta_r <= async_in;
         sync_r <= meta_r;
      end
   end

   assign sync_out = sync_r;
endmodule

// ==== verilog/ext_cond_detect.v ====
// Per-channel level and edge condition detector.
`timescale 1ns/1ps
`include "ext_pin_regs.vh"
module ext_cond_detect #(
   parameter WIDTH = 8
) (
   input wire aclk,
   input wire aresetn,
   input wire [WIDTH-1:0] pin,
   input wire [2*WIDTH-1:0] cond,
   input wire [WIDTH-1:0] level_only,
   output reg [WIDTH-1:0] hit
);
   reg [WIDTH-1:0] prev_r;
   integer i;

   always @(posedge aclk) begin
      if (!aresetn) begin
         prev_r <= {WIDTH{1'b0}};
      end else begin
         prev_r <= pin;
      end
   end

   always @* begin
      hit = {WIDTH{1'b0}};
      for (i = 0; i < WIDTH; i = i + 1) begin
         case (cond[2*i +: 2])
            `COND_LOW: hit[i] = ~pin[i];
            `COND_HIGH: hit[i] = pin[i];
            `COND_RISE: hit[i] = pin[i] & ~prev_r[i] & ~level_only[i];
            `COND_FALL: hit[i] = ~pin[i] & prev_r[i] & ~level_only[i];
            default: hit[i] = 1'b0;
         endcase
      end
   end
endmodule

// ==== verilog/ext_pin_interrupt_unit.v ====
// External pin interrupt unit with AXI4-Lite register access.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ext_pin_regs.vh"
module ext_pin_interrupt_unit #(
   parameter ADDR_W = 12,
   parameter NCH = 8
) (
   input wire aclk,
   input wire aresetn,
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire rmw_read,
   input wire [NCH-1:0] ext_req_pin_default,
   input wire [NCH-1:0] ext_req_pin_alt,
   input wire [1:0] xfer_service_on,
   input wire [1:0] xfer_done,
   output reg [NCH-1:0] chan_req,
   output reg [1:0] vector_req,
   output reg irq
);
   // ----------------------------------------------------------------
   // Address decode.
   // ----------------------------------------------------------------
   localparam SEL_NONE = 3'd0;
   localparam SEL_ENABLES = 3'd1;
   localparam SEL_FLAGS = 3'd2;
   localparam SEL_COND_LO = 3'd3;
   localparam SEL_COND_HI = 3'd4;
   localparam SEL_SELECT = 3'd5;
   localparam SEL_PINS = 3'd6;
   localparam SEL_EVT = 3'd7;
   localparam SEL_W = 3;

   function [SEL_W:0] decode;
      input [ADDR_W-1:0] addr;
      begin
         decode = {1'b0, SEL_NONE};
         if (addr[1:0] == 2'b00) begin
            case (addr[ADDR_W-1:2])
               `IDX_CHAN_REQUEST_ENABLES: decode = {1'b0, SEL_ENABLES};
               `IDX_CHAN_REQUEST_FLAGS: decode = {1'b0, SEL_FLAGS};
               `IDX_DETECT_COND_LOW: decode = {1'b0, SEL_COND_LO};
               `IDX_DETECT_COND_HIGH: decode = {1'b0, SEL_COND_HI};
               `IDX_PIN_SOURCE_SELECT: decode = {1'b0, SEL_SELECT};
               `IDX_PIN_STATE: decode = {1'b0, SEL_PINS};
               `IDX_EVENT_STATUS: decode = {1'b0, SEL_EVT};
               `IDX_EVENT_MASK: decode = {1'b1, SEL_NONE};
               default: decode = {1'b0, SEL_NONE};
            endcase
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // Registers and pin path.
   // ----------------------------------------------------------------
   reg [NCH-1:0] chan_request_enables_r;
   reg [NCH-1:0] chan_request_flags_r;
   reg [2*NCH-1:0] detect_condition_fields_r;
   reg [NCH-1:0] pin_source_select_r;
   reg [NCH-1:0] evt_status_r;
   reg [NCH-1:0] evt_mask_r;
   reg [NCH-1:0] chan_request_flags_nxt;
   reg [NCH-1:0] evt_status_nxt;
   reg [NCH-1:0] level_only;
   reg [NCH-1:0] xfer_clear;
   reg [NCH-1:0] sw_clear;
   reg [NCH-1:0] evt_clear;
   wire [NCH-1:0] pin_default_s;
   wire [NCH-1:0] pin_alt_s;
   wire [NCH-1:0] pin_sel;
   wire [NCH-1:0] hit;
   wire [NCH-1:0] gated;

   ext_pin_sync2 #(
      .WIDTH(NCH)
   ) u_sync_default (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(ext_req_pin_default),
      .sync_out(pin_default_s)
   );

   ext_pin_sync2 #(
      .WIDTH(NCH)
   ) u_sync_alt (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(ext_req_pin_alt),
      .sync_out(pin_alt_s)
   );

   assign pin_sel = (pin_alt_s & pin_source_select_r) |
                    (pin_default_s & ~pin_source_select_r);

   ext_cond_detect #(
      .WIDTH(NCH)
   ) u_detect (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(pin_sel),
      .cond(detect_condition_fields_r),
      .level_only(level_only),
      .hit(hit)
   );

   // ----------------------------------------------------------------
   // Synchroniser fill after reset.
   // ----------------------------------------------------------------
   // The synchronisers leave reset at zero, not at the pin level, so hits are
   // held off until both stages and the edge history hold real samples.
   reg [1:0] fill_cnt_r;
   reg [1:0] fill_cnt_nxt;
   reg fill_done;
   wire [NCH-1:0] hit_ok;

   always @* begin
      fill_done = (fill_cnt_r == `SYNC_FILL_CYCLES);
      fill_cnt_nxt = fill_cnt_r;
      if (!fill_done) begin
         fill_cnt_nxt = fill_cnt_r + 2'h1;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         fill_cnt_r <= `RST_FILL;
      end else begin
         fill_cnt_r <= fill_cnt_nxt;
      end
   end

   assign hit_ok = hit & {NCH{fill_done}};

   // ----------------------------------------------------------------
   // Write channel.
   // ----------------------------------------------------------------
   reg aw_full_r;
   reg w_full_r;
   reg [ADDR_W-1:0] aw_addr_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;
   reg aw_full_nxt;
   reg w_full_nxt;
   reg bvalid_nxt;
   reg do_write;
   reg [SEL_W:0] wsel;
   reg wlane;

   always @* begin
      do_write = aw_full_r & w_full_r & ~s_axi_bvalid;
      wsel = decode(aw_addr_r);
      wlane = do_write & w_strb_r[0];
      aw_full_nxt = (aw_full_r | (s_axi_awvalid & s_axi_awready)) & ~do_write;
      w_full_nxt = (w_full_r | (s_axi_wvalid & s_axi_wready)) & ~do_write;
      bvalid_nxt = do_write | (s_axi_bvalid & ~s_axi_bready);
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         aw_addr_r <= {ADDR_W{1'b0}};
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else begin
         aw_full_r <= aw_full_nxt;
         w_full_r <= w_full_nxt;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         s_axi_awready <= ~aw_full_nxt & ~bvalid_nxt;
         s_axi_wready <= ~w_full_nxt & ~bvalid_nxt;
         s_axi_bvalid <= bvalid_nxt;
         if (do_write) begin
            if (wsel == {1'b0, SEL_NONE} || wsel == {1'b0, SEL_PINS}) begin
               s_axi_bresp <= `RESP_SLVERR;
            end else begin
               s_axi_bresp <= `RESP_OKAY;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers.
   // ----------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         chan_request_enables_r <= `RST_ENABLES;
         detect_condition_fields_r <= {`RST_COND, `RST_COND};
         pin_source_select_r <= `RST_SELECT;
         evt_mask_r <= `RST_EVENT;
      end else if (wlane) begin
         case (wsel)
            {1'b0, SEL_ENABLES}: chan_request_enables_r <= w_data_r[NCH-1:0];
            {1'b0, SEL_COND_LO}: detect_condition_fields_r[NCH-1:0] <= w_data_r[NCH-1:0];
            {1'b0, SEL_COND_HI}: detect_condition_fields_r[2*NCH-1:NCH] <= w_data_r[NCH-1:0];
            {1'b0, SEL_SELECT}: pin_source_select_r <= w_data_r[NCH-1:0];
            {1'b1, SEL_NONE}: evt_mask_r <= w_data_r[NCH-1:0];
            default: evt_mask_r <= evt_mask_r;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Request flags, transfer service and event status.
   // ----------------------------------------------------------------
   always @* begin
      level_only = {{(NCH/2){xfer_service_on[1]}}, {(NCH/2){xfer_service_on[0]}}};
      xfer_clear = {{(NCH/2){xfer_done[1]}}, {(NCH/2){xfer_done[0]}}} &
                   chan_request_enables_r;
      sw_clear = {NCH{1'b0}};
      evt_clear = {NCH{1'b0}};
      if (wlane && wsel == {1'b0, SEL_FLAGS}) begin
         sw_clear = ~w_data_r[NCH-1:0];
      end
      if (wlane && wsel == {1'b0, SEL_EVT}) begin
         evt_clear = w_data_r[NCH-1:0];
      end
      chan_request_flags_nxt = hit_ok |
                               (chan_request_flags_r & ~sw_clear & ~xfer_clear);
      evt_status_nxt = hit_ok | (evt_status_r & ~evt_clear);
   end

   // ----------------------------------------------------------------
   // Next enable and mask values.
   // ----------------------------------------------------------------
   reg [NCH-1:0] chan_request_enables_nxt;
   reg [NCH-1:0] evt_mask_nxt;

   always @* begin
      chan_request_enables_nxt = chan_request_enables_r;
      evt_mask_nxt = evt_mask_r;
      if (wlane && wsel == {1'b0, SEL_ENABLES}) begin
         chan_request_enables_nxt = w_data_r[NCH-1:0];
      end
      if (wlane && wsel == {1'b1, SEL_NONE}) begin
         evt_mask_nxt = w_data_r[NCH-1:0];
      end
   end

   assign gated = chan_request_flags_nxt & chan_request_enables_nxt;

   always @(posedge aclk) begin
      if (!aresetn) begin
         chan_request_flags_r <= `RST_FLAGS;
         evt_status_r <= `RST_EVENT;
      end else begin
         chan_request_flags_r <= chan_request_flags_nxt;
         evt_status_r <= evt_status_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Request and interrupt outputs.
   // ----------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         chan_req <= {NCH{1'b0}};
         vector_req <= 2'b00;
         irq <= 1'b0;
      end else begin
         chan_req <= gated;
         vector_req[0] <= |gated[`VEC0_LSB +: NCH/2];
         vector_req[1] <= |gated[`VEC1_LSB +: NCH/2];
         irq <= |(evt_status_nxt & evt_mask_nxt);
      end
   end

   // ----------------------------------------------------------------
   // Read channel.
   // ----------------------------------------------------------------
   reg [SEL_W:0] rsel;
   reg [NCH-1:0] rval;
   reg rerr;
   reg rtake;

   always @* begin
      rtake = s_axi_arvalid & s_axi_arready;
      rsel = decode(s_axi_araddr);
      rerr = 1'b0;
      case (rsel)
         {1'b0, SEL_ENABLES}: rval = chan_request_enables_r;
         {1'b0, SEL_FLAGS}: rval = rmw_read ? `FLAGS_RMW_VALUE : chan_request_flags_r;
         {1'b0, SEL_COND_LO}: rval = detect_condition_fields_r[NCH-1:0];
         {1'b0, SEL_COND_HI}: rval = detect_condition_fields_r[2*NCH-1:NCH];
         {1'b0, SEL_SELECT}: rval = pin_source_select_r;
         {1'b0, SEL_PINS}: rval = pin_sel;
         {1'b0, SEL_EVT}: rval = evt_status_r;
         {1'b1, SEL_NONE}: rval = evt_mask_r;
         default: begin
            rval = {NCH{1'b0}};
            rerr = 1'b1;
         end
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         if (rtake) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {{(32-NCH){1'b0}}, rval};
            s_axi_rresp <= rerr ? `RESP_SLVERR : `RESP_OKAY;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule

// ==== dv/ext_pin_unit_sva.sv ====
// Port-level assertions of the external pin interrupt unit.
`timescale 1ns/1ps
module ext_pin_unit_sva #(
   parameter ADDR_W = 12,
   parameter NCH = 8
) (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire rmw_read,
   input wire [1:0] xfer_done,
   input wire [NCH-1:0] chan_req,
   input wire [1:0] vector_req
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ----------------------------------------
   // Sequences
   // ----------------------------------------
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rmw_flags;
      s_axi_arvalid && s_axi_arready && rmw_read && s_axi_araddr == 12'h32c;
   endsequence
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_vec0;
      vector_req[0] == |chan_req[3:0];
   endproperty
   a_vec0: assert property (p_vec0) else $error("vector one request wrong");
   property p_vec1;
      vector_req[1] == |chan_req[7:4];
   endproperty
   a_vec1: assert property (p_vec1) else $error("vector two request wrong");
   property p_rmw;
      s_rmw_flags |=> s_axi_rvalid && s_axi_rdata == 32'h0000_00ff;
   endproperty
   a_rmw: assert property (p_rmw) else $error("flag read for update not all ones");
   property p_req_hold;
      (|($past(chan_req) & ~chan_req)) |-> ($rose(s_axi_bvalid) || |$past(xfer_done));
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("request dropped without cause");
   property p_rhigh;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000;
   endproperty
   a_rhigh: assert property (p_rhigh) else $error("read data upper bits set");
   property p_bresp;
      s_wr_taken |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_bresp: assert property (p_bresp) else $error("write response late");
   property p_b_block;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_b_block: assert property (p_b_block) else $error("write taken while response pending");
   property p_r_one;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
   endproperty
   a_r_one: assert property (p_r_one) else $error("read answer not released");
   property p_ar_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("read taken while answer pending");
endmodule

// ==== dv/pin_peer.sv ====
// Far side model: peripheral pin drivers and the transfer service.
`timescale 1ns/1ps
module pin_peer (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] lvl_def,
   input wire [7:0] lvl_alt,
   input wire [1:0] svc_on,
   input wire [1:0] vector_req,
   output wire [7:0] pin_def,
   output wire [7:0] pin_alt,
   output reg [1:0] xfer_done
);
   // Pins are driven as plain inputs of the unit.
   assign pin_def = lvl_def;
   assign pin_alt = lvl_alt;
   // A requesting vector under service gets a transfer and a done pulse.
   always @(posedge aclk) begin
      if (!aresetn) begin
         xfer_done <= 2'h0;
      end else begin
         xfer_done <= svc_on & vector_req & ~xfer_done;
      end
   end
endmodule

// ==== dv/tb.sv ====
// Self-checking bench of the external pin interrupt unit.
`timescale 1ns/1ps
module tb;
   localparam logic [11:0] EN = 12'h328, FL = 12'h32c, CL = 12'h330, CH = 12'h334;
   localparam logic [11:0] SEL = 12'h338, PIN = 12'h340, ST = 12'h344, MK = 12'h348;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, rmw_read = 0;
   logic [7:0] lvl_def = 8'hff, lvl_alt = 8'h00;
   logic [1:0] xfer_service_on = 2'h0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   wire [1:0] s_axi_bresp, s_axi_rresp, vector_req, xfer_done;
   wire [31:0] s_axi_rdata;
   wire [7:0] chan_req, ext_req_pin_default, ext_req_pin_alt;
   int n_fail = 0;
   int compares = 0;
   always #10 aclk = ~aclk;
   ext_pin_interrupt_unit i_ext_pin_interrupt_unit (.*);
   pin_peer i_pin_peer (.aclk(aclk), .aresetn(aresetn), .lvl_def(lvl_def), .lvl_alt(lvl_alt),
      .svc_on(xfer_service_on), .vector_req(vector_req), .pin_def(ext_req_pin_default),
      .pin_alt(ext_req_pin_alt), .xfer_done(xfer_done));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task test_done;
      $display("n_fail %0d compares %0d", n_fail, compares);
      if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [33:0] seen, input logic [33:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      bit got;
      n = 0;
      got = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!got && n < 50) begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            got = 1;
            s_axi_bready <= 1'b0;
            chk({32'h0, s_axi_bresp}, {32'h0, er});
         end
      end
      if (!got) begin
         n_fail++;
         test_done;
      end
   endtask
   task rd(input logic [11:0] a, input logic [7:0] e, input logic rmw, input logic [1:0] er);
      int n;
      bit got;
      n = 0;
      got = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      rmw_read <= rmw;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!got && n < 50) begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            got = 1;
            s_axi_rready <= 1'b0;
            rmw_read <= 1'b0;
            chk({s_axi_rresp, s_axi_rdata}, {er, 24'h00_0000, e});
         end
      end
      if (!got) begin
         n_fail++;
         test_done;
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(EN, 8'h00, 0, 2'h0);
      rd(FL, 8'h00, 0, 2'h0);
      rd(CL, 8'h00, 0, 2'h0);
      rd(CH, 8'h00, 0, 2'h0);
      rd(SEL, 8'h00, 0, 2'h0);
      rd(PIN, 8'hff, 0, 2'h0);
      rd(MK, 8'h00, 0, 2'h0);
      rd(12'h3fc, 8'h00, 0, 2'h2);
      wr(PIN, 8'h00, 2'h2);
      for (int c = 0; c < 4; c++) begin
         lvl_def <= {8{~(c[0] ^ c[1])}};
         wr(CL, {4{c[1:0]}}, 2'h0);
         wr(CH, {4{c[1:0]}}, 2'h0);
         repeat (4) @(posedge aclk);
         wr(FL, 8'h00, 2'h0);
         rd(FL, 8'h00, 0, 2'h0);
         lvl_def <= {8{c[0] ^ c[1]}};
         repeat (4) @(posedge aclk);
         rd(FL, 8'hff, 0, 2'h0);
      end
      wr(FL, 8'hfe, 2'h0);
      rd(FL, 8'hfe, 0, 2'h0);
      wr(FL, 8'h5a, 2'h0);
      rd(FL, 8'h5a, 0, 2'h0);
      rd(FL, 8'hff, 1, 2'h0);
      wr(EN, 8'h13, 2'h0);
      chk({26'h0, chan_req}, {26'h0, 8'h12});
      chk({32'h0, vector_req}, {32'h0, 2'h3});
      wr(EN, 8'hf0, 2'h0);
      chk({32'h0, vector_req}, {32'h0, 2'h2});
      chk({33'h0, irq}, 34'h0);
      wr(MK, 8'h0f, 2'h0);
      chk({33'h0, irq}, 34'h1);
      wr(ST, 8'h0f, 2'h0);
      chk({33'h0, irq}, 34'h0);
      rd(ST, 8'hf0, 0, 2'h0);
      wr(SEL, 8'hff, 2'h0);
      repeat (4) @(posedge aclk);
      rd(PIN, 8'h00, 0, 2'h0);
      lvl_alt <= 8'hff;
      repeat (4) @(posedge aclk);
      rd(PIN, 8'hff, 0, 2'h0);
      wr(EN, 8'h00, 2'h0);
      wr(CL, 8'h55, 2'h0);
      wr(CH, 8'h55, 2'h0);
      lvl_alt <= 8'h00;
      repeat (4) @(posedge aclk);
      wr(EN, 8'hff, 2'h0);
      chk({26'h0, chan_req}, {26'h0, 8'hff});
      xfer_service_on <= 2'h3;
      repeat (4) @(posedge aclk);
      rd(FL, 8'h00, 0, 2'h0);
      wr(CL, 8'haa, 2'h0);
      wr(CH, 8'haa, 2'h0);
      lvl_alt <= 8'hff;
      repeat (4) @(posedge aclk);
      rd(FL, 8'h00, 0, 2'h0);
      test_done;
   end
endmodule
bind ext_pin_interrupt_unit ext_pin_unit_sva #(.ADDR_W(ADDR_W), .NCH(NCH)) i_sva (.*);
